// File: rtl/slp_defs.svh
`ifndef SLP_DEFS_SVH
`define SLP_DEFS_SVH
// Overview of operation
// R1: Always-on core never gated, forces ignored.
// R2: Other domains obey force-up/force-down over state; hibernation and core-off gating still override force-up here.
// R3: Domains gated per main state table.
// R4: Digital core off powers off inner domains.
// R5: Each SRAM bank has its own gate.
// R6: Software forces memories on when retaining.
// R7: System reset starts in digital-active mode.
// R8: Light-sleep stops clocks, stalls CPUs, keeps coprocessor.
// R9: Deep-sleep drops digital core, keeps retention words.
// R10: Hibernation also drops peripherals and memories.
// R11: One-hot bitmap enables each wake source.
// R12: Wake sources allowed per sleep mode.
// R13: Single pad wake by select and level.
// R14: Multi pad wake: any high or all low.
// R15: Deep-sleep GPIO wake uses always-on pads only.
// R16: Any SDIO command wakes.
// R17: UART wakes at threshold plus two edges.
// R18: Readable 48-bit timer on slow clock.
// R19: Only power-up reset clears the timer.
// R20: Vector select 0 boots from slow memory.
// R21: Vector select 1 checks CRC, jumps to entry.
// R22: Software stores CRC and entry before sleep.
// R23: Three-state machine: sleep request, wake return.

// ==================== Register offsets
`define SLP_REG_CTRL      8'h00
`define SLP_REG_FORCE_UP  8'h04
`define SLP_REG_FORCE_DN  8'h08
`define SLP_REG_SRAM_OFF  8'h0C
`define SLP_REG_WAKE_EN   8'h10
`define SLP_REG_PAD_CFG   8'h14
`define SLP_REG_MULTI_MAP 8'h18
`define SLP_REG_TIMER_LO  8'h1C
`define SLP_REG_TIMER_HI  8'h20
`define SLP_REG_ALARM_LO  8'h24
`define SLP_REG_ALARM_HI  8'h28
`define SLP_REG_UART_THR  8'h2C
`define SLP_REG_VEC_SEL   8'h30
`define SLP_REG_STATUS    8'h34
`define SLP_REG_RET_BASE  8'h40
`define SLP_REG_RET_LAST  8'h5C

// ==================== Field positions
`define SLP_CTRL_SLEEP    0
`define SLP_CTRL_MODE_LO  1
`define SLP_CTRL_LP_GO    3
`define SLP_CTRL_DIG_GO   4
`define SLP_PAD_SEL_HI    4
`define SLP_PAD_LV        5
`define SLP_MULTI_LV      6

// ==================== Domain indices
`define SLP_D_PERIPH 0
`define SLP_D_SLOW   1
`define SLP_D_FAST   2
`define SLP_D_DIG    3
`define SLP_D_WLAN   4
`define SLP_D_ROM    5
`define SLP_D_SRAM   6
`define SLP_D_XTAL   7
`define SLP_D_PLL    8
`define SLP_D_OSC8M  9
`define SLP_D_RADIO  10

// ==================== Wake bits and masks
`define SLP_W_SINGLE 0
`define SLP_W_MULTI  1
`define SLP_W_GPIO   2
`define SLP_W_TIMER  3
`define SLP_W_SDIO   4
`define SLP_W_WLAN   5
`define SLP_W_UART0  6
`define SLP_W_TOUCH  8
`define SLP_W_COPROC 9
`define SLP_W_RADIO  10
`define SLP_MASK_LIGHT 11'h7FF
`define SLP_MASK_DEEP  11'h30F
`define SLP_MASK_HIB   11'h00A

// ==================== Reset values and constants
`define SLP_ALARM_RST   48'hFFFF_FFFF_FFFF
`define SLP_UART_THR_RST 10'h000
`define SLP_VEC_SEL_RST 2'h3
`define SLP_VEC_SLOW    32'h5000_0000
`define SLP_VEC_ROM     32'h4000_0400
`define SLP_UART_EXTRA  12'h002
`endif

// File: rtl/slp_pkg.sv
package slp_pkg;
   typedef enum logic [1:0] {ST_DIG_ACTIVE, ST_LP_ACTIVE, ST_LP_SLEEP} slp_state_e;
   typedef enum logic [1:0] {MODE_LIGHT, MODE_DEEP, MODE_HIBERNATE} slp_mode_e;
endpackage

// File: rtl/slp_uart_wake.sv
`timescale 1ns/1ps
`default_nettype none
`include "slp_defs.svh"
module slp_uart_wake (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Control
   input  wire logic       arm,
   input  wire logic [9:0] thresh,
   // Receive line, already synchronised
   input  wire logic       rxd,
   // Result
   output logic            wake_q
);
   logic        rxd_prev_q;
   logic [11:0] edges_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxd_prev_q <= 1'b0;
      end else begin
         rxd_prev_q <= rxd;
      end
   end

   // Saturating count so a noisy line cannot wrap back below threshold
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         edges_q <= 12'h000;
      end else if (!arm) begin
         edges_q <= 12'h000;
      end else if (rxd && !rxd_prev_q && edges_q != 12'hFFF) begin
         edges_q <= edges_q + 12'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= arm && (edges_q >= {2'b00, thresh} + `SLP_UART_EXTRA); // R17
      end
   end
endmodule
`default_nettype wire

// File: rtl/slp_power_ctrl.sv
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "slp_defs.svh"
module slp_power_ctrl import slp_pkg::*; #(
   parameter int NUM_SRAM_BANKS = 3
) (
   // Clock and power-up reset
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   // Register port
   input  wire logic [7:0]                reg_addr,
   input  wire logic [31:0]               reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic      [31:0]               reg_rdata,
   // System reset request and slow clock pins
   input  wire logic                      sys_rst_req,
   input  wire logic                      slow_clk_in,
   // Wake sources
   input  wire logic [17:0]               rtc_pad,
   input  wire logic                      gpio_dig_wake,
   input  wire logic                      gpio_rtc_wake,
   input  wire logic                      sdio_cmd,
   input  wire logic                      wlan_wake,
   input  wire logic [1:0]                uart_rxd,
   input  wire logic                      touch_wake,
   input  wire logic                      coproc_wake,
   input  wire logic                      radio_wake,
   // Boot CRC result from the boot code
   input  wire logic                      crc_done,
   input  wire logic [31:0]               crc_value,
   // Power and clock controls
   output logic                           aon_pwr_en,
   output logic      [10:0]               domain_pwr_en,
   output logic      [NUM_SRAM_BANKS-1:0] sram_bank_en,
   output logic                           cpu_stall,
   output logic                           dig_clk_en,
   output logic      [1:0]                main_state,
   // Boot
   output logic      [31:0]               main_boot_vec,
   output logic      [31:0]               second_boot_vec,
   output logic      [1:0]                crc_check_req
);
   // ==================== Input synchronisers
   localparam int SW = 29;
   logic [SW-1:0] sync1_q, sync2_q;
   logic          s_rst, s_slow, s_gdig, s_grtc, s_sdio, s_wlan;
   logic          s_touch, s_cop, s_radio, slow_prev_q, sdio_prev_q;
   logic [17:0]   s_pad;
   logic [1:0]    s_rxd;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {sys_rst_req, slow_clk_in, rtc_pad, gpio_dig_wake, gpio_rtc_wake,
                     sdio_cmd, wlan_wake, uart_rxd, touch_wake, coproc_wake, radio_wake};
         sync2_q <= sync1_q;
      end
   end
   assign {s_rst, s_slow, s_pad, s_gdig, s_grtc, s_sdio, s_wlan, s_rxd,
           s_touch, s_cop, s_radio} = sync2_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slow_prev_q <= 1'b0;
         sdio_prev_q <= 1'b0;
      end else begin
         slow_prev_q <= s_slow;
         sdio_prev_q <= s_sdio;
      end
   end

   // ==================== Register decode
   slp_state_e  state_q;
   slp_mode_e   mode_q;
   logic [10:0] force_up_q, force_dn_q, wake_en_q, cause_q;
   logic [NUM_SRAM_BANKS-1:0] sram_off_q;
   logic [4:0]  pad_sel_q;
   logic        pad_lv_q, multi_lv_q;
   logic [17:0] multi_map_q;
   logic [47:0] timer_q, alarm_q;
   logic [15:0] tim_hi_snap_q;
   logic [9:0]  uart_thr_q;
   logic [1:0]  vec_sel_q;
   logic [31:0] ret_q [0:7];
   logic        slow_rise, wr_ctrl, sleep_go, wake_evt, wake_exit;
   logic [10:0] wake_raw, wake_ok;
   logic [1:0]  uart_wake;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   function automatic logic [10:0] mode_mask(input slp_mode_e m);
      unique case (m)
         MODE_LIGHT:     return `SLP_MASK_LIGHT;
         MODE_DEEP:      return `SLP_MASK_DEEP;
         MODE_HIBERNATE: return `SLP_MASK_HIB;
         default:        return `SLP_MASK_LIGHT;
      endcase
   endfunction

   assign wr_ctrl  = reg_wr && hit(reg_addr, `SLP_REG_CTRL);
   assign sleep_go = wr_ctrl && reg_wdata[`SLP_CTRL_SLEEP];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         force_up_q  <= '0;
         force_dn_q  <= '0;
         sram_off_q  <= '0;
         wake_en_q   <= '0;
         pad_sel_q   <= '0;
         pad_lv_q    <= 1'b0;
         multi_lv_q  <= 1'b0;
         multi_map_q <= '0;
         alarm_q     <= `SLP_ALARM_RST;
         uart_thr_q  <= `SLP_UART_THR_RST;
         vec_sel_q   <= `SLP_VEC_SEL_RST;
      end else if (reg_wr) begin
         if (hit(reg_addr, `SLP_REG_FORCE_UP))  force_up_q  <= reg_wdata[10:0];
         if (hit(reg_addr, `SLP_REG_FORCE_DN))  force_dn_q  <= reg_wdata[10:0];
         if (hit(reg_addr, `SLP_REG_SRAM_OFF))  sram_off_q  <= reg_wdata[NUM_SRAM_BANKS-1:0];
         if (hit(reg_addr, `SLP_REG_WAKE_EN))   wake_en_q   <= reg_wdata[10:0]; // R11
         if (hit(reg_addr, `SLP_REG_PAD_CFG)) begin
            pad_sel_q  <= reg_wdata[`SLP_PAD_SEL_HI:0];
            pad_lv_q   <= reg_wdata[`SLP_PAD_LV];
            multi_lv_q <= reg_wdata[`SLP_MULTI_LV];
         end
         if (hit(reg_addr, `SLP_REG_MULTI_MAP)) multi_map_q    <= reg_wdata[17:0];
         if (hit(reg_addr, `SLP_REG_ALARM_LO))  alarm_q[31:0]  <= reg_wdata;
         if (hit(reg_addr, `SLP_REG_ALARM_HI))  alarm_q[47:32] <= reg_wdata[15:0];
         if (hit(reg_addr, `SLP_REG_UART_THR))  uart_thr_q     <= reg_wdata[9:0];
         if (hit(reg_addr, `SLP_REG_VEC_SEL))   vec_sel_q      <= reg_wdata[1:0];
      end
   end

   // Retention words sit on the always-on core and hold through every sleep
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 8; i++) ret_q[i] <= '0;
      end else if (reg_wr && reg_addr >= `SLP_REG_RET_BASE
                   && reg_addr <= `SLP_REG_RET_LAST && reg_addr[1:0] == 2'b00) begin
         ret_q[3'(reg_addr[4:2])] <= reg_wdata; // R9
      end
   end

   // ==================== Timer
   assign slow_rise = s_slow && !slow_prev_q;

   // Only the power-up reset touches it; system reset and sleep do not
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_q <= '0; // R19
      end else if (slow_rise) begin
         timer_q <= timer_q + 48'h1; // R18
      end
   end

   // High half is frozen by a low read so a carry between reads is not seen
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tim_hi_snap_q <= '0;
      end else if (reg_rd && hit(reg_addr, `SLP_REG_TIMER_LO)) begin
         tim_hi_snap_q <= timer_q[47:32];
      end
   end

   // ==================== Wake sources
   for (genvar u = 0; u < 2; u++) begin : g_uart
      slp_uart_wake u_uart (
         .clk    (clk),
         .rst_n  (rst_n),
         .arm    (state_q == ST_LP_SLEEP),
         .thresh (uart_thr_q),
         .rxd    (s_rxd[u]),
         .wake_q (uart_wake[u])
      );
   end

   always_comb begin
      wake_raw = '0;
      wake_raw[`SLP_W_SINGLE] = pad_sel_q < 5'd18 &&
                                s_pad[pad_sel_q] == pad_lv_q; // R13
      wake_raw[`SLP_W_MULTI]  = multi_lv_q ? |(s_pad & multi_map_q)
                                : (multi_map_q != '0 && (s_pad & multi_map_q) == '0); // R14
      wake_raw[`SLP_W_GPIO]   = (mode_q == MODE_DEEP) ? s_grtc : (s_grtc | s_gdig); // R15
      wake_raw[`SLP_W_TIMER]  = timer_q >= alarm_q; // R18
      wake_raw[`SLP_W_SDIO]   = s_sdio && !sdio_prev_q; // R16
      wake_raw[`SLP_W_WLAN]   = s_wlan;
      wake_raw[`SLP_W_UART0+:2] = uart_wake; // R17
      wake_raw[`SLP_W_TOUCH]  = s_touch;
      wake_raw[`SLP_W_COPROC] = s_cop;
      wake_raw[`SLP_W_RADIO]  = s_radio;
   end

   assign wake_ok   = wake_raw & wake_en_q & mode_mask(mode_q); // R11 R12
   assign wake_evt  = state_q == ST_LP_SLEEP && wake_ok != '0;
   assign wake_exit = wake_evt && !s_rst;

   // ==================== Main state machine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_DIG_ACTIVE; // R7
      end else if (s_rst) begin
         state_q <= ST_DIG_ACTIVE; // R7
      end else begin
         unique case (state_q)
            ST_DIG_ACTIVE: begin
               if (sleep_go) state_q <= ST_LP_SLEEP; // R23
               else if (wr_ctrl && reg_wdata[`SLP_CTRL_LP_GO]) state_q <= ST_LP_ACTIVE;
            end
            ST_LP_ACTIVE: begin
               if (sleep_go) state_q <= ST_LP_SLEEP;
               else if (wr_ctrl && reg_wdata[`SLP_CTRL_DIG_GO]) state_q <= ST_DIG_ACTIVE;
            end
            ST_LP_SLEEP: begin
               if (wake_evt) state_q <= ST_DIG_ACTIVE; // R23
            end
            default: state_q <= ST_DIG_ACTIVE;
         endcase
      end
   end

   // Mode is latched only while awake so a sleep cannot change under itself
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= MODE_LIGHT;
      end else if (sleep_go && state_q != ST_LP_SLEEP) begin
         mode_q <= slp_mode_e'(reg_wdata[`SLP_CTRL_MODE_LO+:2]);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cause_q <= '0;
      end else if (wake_exit) begin
         // Wake capture beats a clearing write in the same cycle
         cause_q <= wake_ok;
      end else if (sleep_go) begin
         cause_q <= '0;
      end
   end

   // ==================== Power gating
   logic [10:0] base_pwr, pwr_d;
   logic        sleeping, hib;
   assign sleeping = state_q == ST_LP_SLEEP;
   assign hib      = sleeping && mode_q == MODE_HIBERNATE;

   always_comb begin
      base_pwr = (state_q == ST_DIG_ACTIVE) ? 11'h7FF : 11'h000; // R3
      base_pwr[`SLP_D_PERIPH] = !sleeping; // R3
      if (sleeping && mode_q == MODE_LIGHT) begin
         // Light sleep keeps peripherals, core, ROM and SRAM powered; slow and fast memory, clocks and radio stop
         base_pwr[`SLP_D_PERIPH] = 1'b1; // R8
         base_pwr[`SLP_D_DIG]    = 1'b1;
         base_pwr[`SLP_D_ROM]    = 1'b1;
         base_pwr[`SLP_D_SRAM]   = 1'b1;
      end
      pwr_d = (base_pwr | force_up_q) & ~force_dn_q; // R2
      if (hib) begin
         pwr_d[`SLP_D_PERIPH] = 1'b0; // R10
         pwr_d[`SLP_D_SLOW]   = 1'b0;
         pwr_d[`SLP_D_FAST]   = 1'b0;
      end
      if (!pwr_d[`SLP_D_DIG]) begin
         pwr_d[`SLP_D_WLAN] = 1'b0; // R4
         pwr_d[`SLP_D_ROM]  = 1'b0;
         pwr_d[`SLP_D_SRAM] = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aon_pwr_en    <= 1'b1;
         domain_pwr_en <= 11'h7FF;
         sram_bank_en  <= '1;
         cpu_stall     <= 1'b0;
         dig_clk_en    <= 1'b1;
         main_state    <= 2'h0;
      end else begin
         aon_pwr_en    <= 1'b1; // R1
         domain_pwr_en <= pwr_d;
         sram_bank_en  <= {NUM_SRAM_BANKS{pwr_d[`SLP_D_SRAM]}} & ~sram_off_q; // R5
         cpu_stall     <= state_q != ST_DIG_ACTIVE; // R8
         dig_clk_en    <= state_q == ST_DIG_ACTIVE; // R8
         main_state    <= state_q;
      end
   end

   // ==================== Boot vectors
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         main_boot_vec   <= `SLP_VEC_ROM;
         second_boot_vec <= `SLP_VEC_ROM;
         crc_check_req   <= 2'b00;
      end else if (wake_exit) begin
         main_boot_vec   <= vec_sel_q[0] ? `SLP_VEC_ROM : `SLP_VEC_SLOW; // R20
         second_boot_vec <= vec_sel_q[1] ? `SLP_VEC_ROM : `SLP_VEC_SLOW;
         crc_check_req   <= vec_sel_q; // R21
      end else if (crc_done) begin
         // A mismatch leaves the ROM vector, so boot falls back to flash
         if (crc_check_req[0] && crc_value == ret_q[6]) main_boot_vec <= ret_q[7]; // R21
         if (crc_check_req[1] && crc_value == ret_q[6]) second_boot_vec <= ret_q[7];
         crc_check_req <= 2'b00;
      end
   end

   // ==================== Read port
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= '0;
         unique case (reg_addr)
            `SLP_REG_FORCE_UP:  reg_rdata <= {21'h0, force_up_q};
            `SLP_REG_FORCE_DN:  reg_rdata <= {21'h0, force_dn_q};
            `SLP_REG_SRAM_OFF:  reg_rdata <= 32'(sram_off_q);
            `SLP_REG_WAKE_EN:   reg_rdata <= {21'h0, wake_en_q};
            `SLP_REG_PAD_CFG:   reg_rdata <= {25'h0, multi_lv_q, pad_lv_q, pad_sel_q};
            `SLP_REG_MULTI_MAP: reg_rdata <= {14'h0, multi_map_q};
            `SLP_REG_TIMER_LO:  reg_rdata <= timer_q[31:0];
            `SLP_REG_TIMER_HI:  reg_rdata <= {16'h0, tim_hi_snap_q};
            `SLP_REG_ALARM_LO:  reg_rdata <= alarm_q[31:0];
            `SLP_REG_ALARM_HI:  reg_rdata <= {16'h0, alarm_q[47:32]};
            `SLP_REG_UART_THR:  reg_rdata <= {22'h0, uart_thr_q};
            `SLP_REG_VEC_SEL:   reg_rdata <= {30'h0, vec_sel_q};
            `SLP_REG_STATUS:    reg_rdata <= {17'h0, cause_q, mode_q, state_q};
            default: begin
               if (reg_addr >= `SLP_REG_RET_BASE && reg_addr <= `SLP_REG_RET_LAST
                   && reg_addr[1:0] == 2'b00) reg_rdata <= ret_q[3'(reg_addr[4:2])];
            end
         endcase
      end
   end

   // ==================== Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_wake_exit;
      wake_exit ##1 state_q == ST_DIG_ACTIVE;
   endsequence

   chk_aon_always_on: assert property (##1 aon_pwr_en) // R1
      else $error("always-on domain gated");
   chk_force_down_pll: assert property (force_dn_q[`SLP_D_PLL] |=> !domain_pwr_en[`SLP_D_PLL]) // R2
      else $error("force down ignored");
   chk_dig_inner_off: assert property (!domain_pwr_en[`SLP_D_DIG] |-> // R4
         !domain_pwr_en[`SLP_D_WLAN] && !domain_pwr_en[`SLP_D_ROM]
         && !domain_pwr_en[`SLP_D_SRAM])
      else $error("inner domain on with core off");
   chk_bank_off: assert property (sram_off_q[0] |=> !sram_bank_en[0]) // R5
      else $error("bank not gated");
   chk_sleep_xtal_off: assert property (sleeping && !force_up_q[`SLP_D_XTAL] // R8
         |=> !domain_pwr_en[`SLP_D_XTAL] && cpu_stall)
      else $error("crystal on in sleep");
   chk_hib_mem_off: assert property (hib |=> !domain_pwr_en[`SLP_D_SLOW] // R10
         && !domain_pwr_en[`SLP_D_FAST] && !domain_pwr_en[`SLP_D_PERIPH])
      else $error("memory on in hibernation");
   chk_hib_wake_sources: assert property (hib // R12
         && (wake_raw & wake_en_q & `SLP_MASK_HIB) == 11'h000 |-> !wake_evt)
      else $error("disallowed source woke hibernation");
   chk_wake_return: assert property (s_wake_exit |=> main_state == ST_DIG_ACTIVE) // R23
      else $error("no return to active on wake");
   chk_timer_count: assert property (slow_rise |=> timer_q == $past(timer_q) + 48'h1) // R18
      else $error("timer did not advance");
   chk_slow_vector: assert property (wake_exit && !vec_sel_q[0] // R20
         |=> main_boot_vec == `SLP_VEC_SLOW && !crc_check_req[0])
      else $error("slow memory vector not set");
endmodule
`default_nettype wire

// File: tb/slp_wake_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==================== Wake source model
module slp_wake_model (
   // Clock
   input  wire logic        clk,
   // Wake sources and slow clock
   output logic      [17:0] rtc_pad,
   output logic      [1:0]  gpio,
   output logic             sdio_cmd,
   output logic      [1:0]  uart_rxd,
   output logic      [3:0]  misc_wake,
   output logic             slow_clk
);
   logic [2:0] div_q;
   initial begin
      div_q = 3'h0;
      rtc_pad = 18'h0;
      gpio = 2'h0;
      sdio_cmd = 1'b0;
      uart_rxd = 2'h3;
      misc_wake = 4'h0;
   end
   // Oscillator runs free, also through sleep
   always @(posedge clk) begin
      div_q <= div_q + 3'h1;
   end
   assign slow_clk = div_q[2];
   task automatic set_pads(input logic [17:0] v);
      @(posedge clk);
      rtc_pad <= v;
   endtask
   task automatic set_gpio(input logic [1:0] v);
      @(posedge clk);
      gpio <= v;
   endtask
   // Bit order: wireless, touch, coprocessor, radio
   task automatic set_misc(input logic [3:0] v);
      @(posedge clk);
      misc_wake <= v;
   endtask
   task automatic sdio_pulse;
      @(posedge clk);
      sdio_cmd <= 1'b1;
      repeat (4) @(posedge clk);
      sdio_cmd <= 1'b0;
   endtask
   // Edges spaced past the 2-ff sync so none merge
   task automatic uart_edges(input int n);
      repeat (n) begin
         @(posedge clk);
         uart_rxd <= 2'h2;
         repeat (3) @(posedge clk);
         uart_rxd <= 2'h3;
         repeat (3) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// File: tb/sleep_wakeup_power_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "slp_defs.svh"
module sleep_wakeup_power_control_bench;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        sys_rst_req = 1'b0;
   logic        crc_done = 1'b0;
   logic [31:0] crc_value = 32'h0;
   logic [31:0] reg_rdata, main_boot_vec, second_boot_vec, a, b;
   logic [17:0] rtc_pad;
   logic [1:0]  gpio, uart_rxd, main_state, crc_check_req;
   logic        sdio_cmd, slow_clk, aon_pwr_en, cpu_stall, dig_clk_en;
   logic [10:0] domain_pwr_en;
   logic [3:0]  misc_wake;
   logic [2:0]  sram_bank_en;
   int          n_fail = 0;
   int          n_tests = 0;
   always #12.5 clk = ~clk;
   slp_wake_model src (.clk(clk), .rtc_pad(rtc_pad), .gpio(gpio), .sdio_cmd(sdio_cmd),
      .uart_rxd(uart_rxd), .misc_wake(misc_wake), .slow_clk(slow_clk));
   slp_power_ctrl #(.NUM_SRAM_BANKS(3)) uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sys_rst_req(sys_rst_req), .slow_clk_in(slow_clk), .rtc_pad(rtc_pad),
      .gpio_dig_wake(gpio[0]), .gpio_rtc_wake(gpio[1]), .sdio_cmd(sdio_cmd),
      .wlan_wake(misc_wake[0]), .uart_rxd(uart_rxd), .touch_wake(misc_wake[1]),
      .coproc_wake(misc_wake[2]), .radio_wake(misc_wake[3]), .crc_done(crc_done),
      .crc_value(crc_value),
      .aon_pwr_en(aon_pwr_en), .domain_pwr_en(domain_pwr_en), .sram_bank_en(sram_bank_en),
      .cpu_stall(cpu_stall), .dig_clk_en(dig_clk_en), .main_state(main_state),
      .main_boot_vec(main_boot_vec), .second_boot_vec(second_boot_vec),
      .crc_check_req(crc_check_req));
   // ==================== Shared tasks
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Data is registered at the strobe edge and holds until the next read
   task automatic rd(input logic [7:0] ad, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic wait_st(input logic [1:0] s);
      int i;
      for (i = 0; i < 20 && main_state !== s; i++) @(posedge clk);
      #1 check(main_state, s);
   endtask
   task automatic hold_sleep;
      repeat (8) @(posedge clk);
      #1 check(main_state, 2'h2);
   endtask
   // ==================== Scenarios
   task automatic t_reset;
      check(domain_pwr_en, 11'h7FF);
      check(main_state, 2'h0);
      check(aon_pwr_en, 1'b1);
      check(main_boot_vec, 32'h4000_0400);
      rd(`SLP_REG_STATUS, a);
      check(a, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_deep;
      wr(`SLP_REG_FORCE_UP, 32'h2);
      wr(`SLP_REG_VEC_SEL, 32'h0);
      wr(`SLP_REG_PAD_CFG, 32'h23);
      wr(`SLP_REG_WAKE_EN, 32'h405);
      wr(`SLP_REG_CTRL, 32'h3);
      wait_st(2'h2);
      check(domain_pwr_en, 11'h002);
      check(aon_pwr_en, 1'b1);
      check(cpu_stall, 1'b1);
      src.set_gpio(2'h1);
      src.set_misc(4'h8);
      hold_sleep();
      src.set_gpio(2'h0);
      src.set_misc(4'h0);
      src.set_pads(18'h8);
      wait_st(2'h0);
      check(main_boot_vec, 32'h5000_0000);
      check(second_boot_vec, 32'h5000_0000);
      src.set_pads(18'h0);
      $display("deep sleep test done");
   endtask
   task automatic t_hib;
      wr(`SLP_REG_MULTI_MAP, 32'h20);
      wr(`SLP_REG_PAD_CFG, 32'h40);
      wr(`SLP_REG_WAKE_EN, 32'h312);
      wr(`SLP_REG_CTRL, 32'h5);
      wait_st(2'h2);
      check(domain_pwr_en, 11'h000);
      src.set_misc(4'h6);
      src.sdio_pulse();
      hold_sleep();
      src.set_misc(4'h0);
      src.set_pads(18'h20);
      wait_st(2'h0);
      src.set_pads(18'h0);
      $display("hibernation test done");
   endtask
   task automatic t_light;
      wr(`SLP_REG_VEC_SEL, 32'h3);
      wr(8'h58, 32'hC0DE_0006);
      wr(8'h5C, 32'h5000_0100);
      wr(`SLP_REG_UART_THR, 32'h3);
      wr(`SLP_REG_WAKE_EN, 32'h40);
      wr(`SLP_REG_CTRL, 32'h1);
      wait_st(2'h2);
      check(domain_pwr_en, 11'h06B);
      check(dig_clk_en, 1'b0);
      src.uart_edges(4);
      hold_sleep();
      src.uart_edges(1);
      wait_st(2'h0);
      check(crc_check_req, 2'h3);
      @(posedge clk);
      crc_done <= 1'b1;
      crc_value <= 32'hC0DE_0006;
      @(posedge clk);
      crc_done <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check(main_boot_vec, 32'h5000_0100);
      check(second_boot_vec, 32'h5000_0100);
      check(crc_check_req, 2'h0);
      rd(`SLP_REG_STATUS, a);
      check(a, 32'h400);
      $display("light sleep test done");
   endtask
   task automatic t_force;
      wr(`SLP_REG_CTRL, 32'h8);
      wait_st(2'h1);
      check(domain_pwr_en, 11'h003);
      wr(`SLP_REG_CTRL, 32'h10);
      wait_st(2'h0);
      wr(`SLP_REG_FORCE_DN, 32'h10A);
      repeat (3) @(posedge clk);
      #1 check(domain_pwr_en, 11'h685);
      check(aon_pwr_en, 1'b1);
      wr(`SLP_REG_FORCE_DN, 32'h0);
      wr(`SLP_REG_SRAM_OFF, 32'h3);
      repeat (3) @(posedge clk);
      #1 check(sram_bank_en, 3'h4);
      wr(`SLP_REG_SRAM_OFF, 32'h0);
      $display("force test done");
   endtask
   task automatic t_timer;
      rd(`SLP_REG_TIMER_LO, a);
      wr(`SLP_REG_WAKE_EN, 32'h0);
      wr(`SLP_REG_CTRL, 32'h1);
      wait_st(2'h2);
      @(posedge clk);
      sys_rst_req <= 1'b1;
      repeat (6) @(posedge clk);
      sys_rst_req <= 1'b0;
      wait_st(2'h0);
      rd(`SLP_REG_TIMER_LO, b);
      check(b > a, 1'b1);
      // Alarm four slow ticks ahead: lands after the sleep hold below
      wr(`SLP_REG_ALARM_HI, 32'h0);
      wr(`SLP_REG_ALARM_LO, b + 32'h4);
      wr(`SLP_REG_WAKE_EN, 32'h8);
      wr(`SLP_REG_CTRL, 32'h5);
      wait_st(2'h2);
      hold_sleep();
      wait_st(2'h0);
      $display("timer test done");
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1 t_reset();
      t_deep();
      t_hib();
      t_light();
      t_force();
      t_timer();
      summarize();
   end
   // Whole run needs well under 2000 cycles
   initial begin
      #(25 * 5000);
      n_fail++;
      summarize();
   end
endmodule
`default_nettype wire
